// ===== hw/lomr_pkg.sv
// Constants and types for the line output mixer register slice
package lomr_pkg;

  // ----------------------------------------------------------
  // Bus widths
  // ----------------------------------------------------------
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;

  // ----------------------------------------------------------
  // Register indices; byte address is four times the index
  // ----------------------------------------------------------
  localparam logic [7:0] IDX_RSVD_A = 8'h4f;
  localparam logic [7:0] IDX_RSVD_B = 8'h50;
  localparam logic [7:0] IDX_LA_LL  = 8'h51;
  localparam logic [7:0] IDX_LD_LL  = 8'h52;
  localparam logic [7:0] IDX_RSVD_C = 8'h53;
  localparam logic [7:0] IDX_RA_LL  = 8'h54;
  localparam logic [7:0] IDX_RD_LL  = 8'h55;
  localparam logic [7:0] IDX_LEVEL  = 8'h56;
  localparam logic [7:0] IDX_RSVD_D = 8'h57;
  localparam logic [7:0] IDX_LA_RL  = 8'h58;
  localparam logic [7:0] IDX_LD_RL  = 8'h59;
  localparam logic [7:0] IDX_RSVD_E = 8'h5a;
  localparam logic [7:0] IDX_RA_RL  = 8'h5b;
  localparam logic [7:0] IDX_RD_RL  = 8'h5c;

  // ----------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------
  localparam int ROUTE_EN_BIT = 7;
  localparam int VOL_MSB      = 6;
  localparam int LVL_MSB      = 7;
  localparam int LVL_LSB      = 4;
  localparam int UNMUTE_BIT   = 3;
  localparam int DONE_BIT     = 1;
  localparam int PWR_BIT      = 0;

  // ----------------------------------------------------------
  // Values after reset
  // ----------------------------------------------------------
  localparam logic [7:0] RSVD_A_RST = 8'h02;
  localparam logic [7:0] RSVD_B_RST = 8'h00;
  localparam logic [7:0] RSVD_RST   = 8'h00;
  localparam logic [7:0] ROUTE_RST  = 8'h00;
  localparam logic [3:0] LVL_RST    = 4'h0;
  localparam logic       UNMUTE_RST = 1'b0;
  localparam logic       PWR_RST    = 1'b0;
  localparam logic       DONE_RST   = 1'b1;

  // ----------------------------------------------------------
  // Gain settle time
  // ----------------------------------------------------------
  localparam int CLK_NS     = 10;
  localparam int SETTLE_NS  = 1000;
  localparam int SETTLE_CYC = (SETTLE_NS + CLK_NS - 1) / CLK_NS;
  localparam int CNT_W      = 7;

  // ----------------------------------------------------------
  // Bus answer phases
  // ----------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_RESP = 2'b10
  } lomr_apb_e;

endpackage

// ===== hw/lomr_regs.sv
// Line output mixer register slice with APB slave port
//
// Added by the designer: register access over APB.
`timescale 1ns/1ps
module lomr_regs
  import lomr_pkg::*;
(
  input  wire logic              i_sys_clk,
  input  wire logic              i_srst,
  input  wire logic              i_psel,
  input  wire logic              i_penable,
  input  wire logic              i_pwrite,
  input  wire logic [ADDR_W-1:0] i_paddr,
  input  wire logic [DATA_W-1:0] i_pwdata,
  input  wire logic [3:0]        i_pstrb,
  output logic                   o_pready,
  output logic      [DATA_W-1:0] o_prdata,
  output logic                   o_pslverr,
  output logic      [7:0]        o_route_en,
  output logic      [55:0]       o_route_vol,
  output logic      [3:0]        o_left_level,
  output logic                   o_left_unmute,
  output logic                   o_left_power,
  output logic                   o_left_gain_done
);

  // ----------------------------------------------------------
  // State
  // ----------------------------------------------------------
  lomr_apb_e          st_r;
  logic [7:0]         route_r [8];
  logic [7:0]         rsvd_r  [3];
  logic [3:0]         lvl_r;
  logic               unmute_r;
  logic               pwr_r;
  logic [CNT_W-1:0]   cnt_r;
  logic [CNT_W-1:0]   cnt_nxt;
  logic               done_r;
  logic               pready_r;
  logic               pslverr_r;
  logic [DATA_W-1:0]  prdata_r;

  // ----------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------
  logic [7:0] idx;
  logic       hit;
  logic       is_route;
  logic [2:0] route_sel;
  logic       is_rsvd;
  logic [1:0] rsvd_sel;
  logic       is_level;
  logic       is_left;
  logic [7:0] rd_byte;
  logic       commit;

  assign idx = i_paddr[9:2];

  // Misaligned or out-of-page addresses never hit
  always_comb begin
    hit       = 1'b1;
    is_route  = 1'b0;
    route_sel = 3'd0;
    is_rsvd   = 1'b0;
    rsvd_sel  = 2'd0;
    is_level  = 1'b0;
    rd_byte   = 8'h00;
    if (i_paddr[1:0] != 2'b00 || i_paddr[11:10] != 2'b00) begin
      hit = 1'b0;
    end else if (idx == IDX_RSVD_A) begin
      rd_byte = RSVD_A_RST;
    end else if (idx == IDX_RSVD_B) begin
      rd_byte = RSVD_B_RST;
    end else if (idx == IDX_LA_LL) begin
      is_route  = 1'b1;
      route_sel = 3'd0;
    end else if (idx == IDX_LD_LL) begin
      is_route  = 1'b1;
      route_sel = 3'd1;
    end else if (idx == IDX_RSVD_C) begin
      is_rsvd  = 1'b1;
      rsvd_sel = 2'd0;
    end else if (idx == IDX_RA_LL) begin
      is_route  = 1'b1;
      route_sel = 3'd2;
    end else if (idx == IDX_RD_LL) begin
      is_route  = 1'b1;
      route_sel = 3'd3;
    end else if (idx == IDX_LEVEL) begin
      is_level = 1'b1;
    end else if (idx == IDX_RSVD_D) begin
      is_rsvd  = 1'b1;
      rsvd_sel = 2'd1;
    end else if (idx == IDX_LA_RL) begin
      is_route  = 1'b1;
      route_sel = 3'd4;
    end else if (idx == IDX_LD_RL) begin
      is_route  = 1'b1;
      route_sel = 3'd5;
    end else if (idx == IDX_RSVD_E) begin
      is_rsvd  = 1'b1;
      rsvd_sel = 2'd2;
    end else if (idx == IDX_RA_RL) begin
      is_route  = 1'b1;
      route_sel = 3'd6;
    end else if (idx == IDX_RD_RL) begin
      is_route  = 1'b1;
      route_sel = 3'd7;
    end else begin
      hit = 1'b0;
    end
    if (is_route) begin
      rd_byte = route_r[route_sel];
    end else if (is_rsvd) begin
      rd_byte = rsvd_r[rsvd_sel];
    end else if (is_level) begin
      // Bit 2 always reads zero
      rd_byte = {lvl_r, unmute_r, 1'b0, done_r, pwr_r};
    end
  end

  // Left line routes are selectors 0..3
  assign is_left = is_route && !route_sel[2];

  // Write lands only at the edge that completes the access
  assign commit = (st_r == ST_RESP) && i_psel && i_penable &&
                  i_pwrite && hit && i_pstrb[0];

  // ----------------------------------------------------------
  // APB answer: one wait state, all outputs registered
  // ----------------------------------------------------------
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      st_r      <= ST_IDLE;
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h0000_0000;
    end else begin
      case (st_r)
        ST_IDLE: begin
          if (i_psel && i_penable) begin
            st_r      <= ST_RESP;
            pready_r  <= 1'b1;
            pslverr_r <= !hit;
            prdata_r  <= (i_pwrite || !hit) ? 32'h0000_0000 :
                         {24'h00_0000, rd_byte};
          end
        end
        ST_RESP: begin
          st_r      <= ST_IDLE;
          pready_r  <= 1'b0;
          pslverr_r <= 1'b0;
          prdata_r  <= 32'h0000_0000;
        end
        default: begin
          st_r      <= ST_IDLE;
          pready_r  <= 1'b0;
          pslverr_r <= 1'b0;
          prdata_r  <= 32'h0000_0000;
        end
      endcase
    end
  end

  // ----------------------------------------------------------
  // Route registers
  // ----------------------------------------------------------
  // Enable and volume held as written; no gain mapping here
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      for (int i = 0; i < 8; i++) begin
        route_r[i] <= ROUTE_RST;
      end
    end else if (commit && is_route) begin
      route_r[route_sel] <= i_pwdata[7:0];
    end
  end

  // Reserved read/write registers keep what is written
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      for (int i = 0; i < 3; i++) begin
        rsvd_r[i] <= RSVD_RST;
      end
    end else if (commit && is_rsvd) begin
      rsvd_r[rsvd_sel] <= i_pwdata[7:0];
    end
  end

  // ----------------------------------------------------------
  // Left line level, mute and power
  // ----------------------------------------------------------
  // Level codes above 9 are stored as written; software avoids them
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      lvl_r    <= LVL_RST;
      unmute_r <= UNMUTE_RST;
      pwr_r    <= PWR_RST;
    end else if (commit && is_level) begin
      lvl_r    <= i_pwdata[LVL_MSB:LVL_LSB];
      unmute_r <= i_pwdata[UNMUTE_BIT];
      pwr_r    <= i_pwdata[PWR_BIT];
    end
  end

  // ----------------------------------------------------------
  // Gain-applied status
  // ----------------------------------------------------------
  // A new level or left route write restarts the settle wait, so a burst of
  // volume changes reports pending until the last one settles
  always_comb begin
    cnt_nxt = cnt_r;
    if (commit && (is_level || is_left)) begin
      cnt_nxt = CNT_W'(SETTLE_CYC);
    end else if (cnt_r != '0) begin
      cnt_nxt = cnt_r - 1'b1;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      cnt_r  <= '0;
      done_r <= DONE_RST;
    end else begin
      cnt_r  <= cnt_nxt;
      done_r <= (cnt_nxt == '0);
    end
  end

  // ----------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------
  // Each route drives its enable and raw volume code
  for (genvar g = 0; g < 8; g++) begin : g_route
    assign o_route_en[g] = route_r[g][ROUTE_EN_BIT];
    assign o_route_vol[g*7 +: 7] =
      route_r[g][VOL_MSB:0];
  end

  assign o_pready         = pready_r;
  assign o_pslverr        = pslverr_r;
  assign o_prdata         = prdata_r;
  assign o_left_level     = lvl_r;
  assign o_left_unmute    = unmute_r;
  assign o_left_power     = pwr_r;
  assign o_left_gain_done = done_r;

  // ----------------------------------------------------------
  // Checks
  // ----------------------------------------------------------
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_srst);

  a_reset_values: assert property (
    $past(i_srst) |-> (o_route_en == 8'h00) && !o_left_unmute &&
      o_left_gain_done && (o_route_vol == '0))
    else $error("Reset values wrong");

  a_route_write_lands: assert property (
    (commit && is_route) |=>
      route_r[$past(route_sel)] == $past(i_pwdata[7:0]))
    else $error("Route write lost");

  a_level_write_lands: assert property (
    (commit && is_level) |=>
      (o_left_level == $past(i_pwdata[7:4])) &&
      (o_left_unmute == $past(i_pwdata[3])) &&
      (o_left_power == $past(i_pwdata[0])))
    else $error("Level write lost");

  a_gain_pending: assert property (
    (commit && (is_level || is_left)) |=> !o_left_gain_done)
    else $error("Status not pending after gain write");

  a_done_tracks_cnt: assert property (
    o_left_gain_done == (cnt_r == '0))
    else $error("Status disagrees with settle counter");

  a_rsvd_a_reads: assert property (
    ((st_r == ST_IDLE) && i_psel && i_penable && !i_pwrite &&
     (i_paddr == {2'b00, IDX_RSVD_A, 2'b00}))
      |=> o_pready && (o_prdata == 32'h0000_0002))
    else $error("Reserved 79 read wrong");

  a_bit2_zero: assert property (
    (o_pready && !i_pwrite && is_level) |-> !o_prdata[2])
    else $error("Level bit 2 not zero");

  a_pready_one_cycle: assert property (
    (i_psel && i_penable && !o_pready) |=> o_pready ##1 !o_pready)
    else $error("Ready not a single pulse");

  // Bus answer checks: refusals, reserved B reads, idle data and where writes land
  a_unmapped_error: assert property (
    ((st_r == ST_IDLE) && i_psel && i_penable && !hit) |=>
      o_pready && o_pslverr && (o_prdata == '0))
    else $error("Unmapped access not refused");

  a_rsvd_b_reads: assert property (
    ((st_r == ST_IDLE) && i_psel && i_penable && !i_pwrite &&
     (i_paddr == {2'b00, IDX_RSVD_B, 2'b00}))
      |=> o_pready && (o_prdata == {24'h00_0000, RSVD_B_RST}))
    else $error("Reserved b read wrong");

  a_prdata_idle: assert property (
    !o_pready |-> (o_prdata == '0))
    else $error("Read data outside answer cycle");

  a_commit_in_answer: assert property (
    commit |-> o_pready && !o_pslverr)
    else $error("Write landed outside answer cycle");

  // A write with its low strobe off must leave the route, level and unmute outputs alone
  a_strobe_off_keeps: assert property (
    ((st_r == ST_RESP) && i_psel && i_penable && i_pwrite &&
     !i_pstrb[0]) |=> $stable(o_route_en) && $stable(o_route_vol) &&
      $stable(o_left_level) && $stable(o_left_unmute))
    else $error("Write with strobe off changed a register");

  // Right routes never hold the left output's status pending
  a_right_no_pending: assert property (
    (commit && is_route && route_sel[2] && (cnt_r == '0)) |=>
      o_left_gain_done)
    else $error("Right route write made left status pending");

  a_cnt_bounded: assert property (
    cnt_r <= CNT_W'(SETTLE_CYC))
    else $error("Settle counter out of range");

  c_route_write: cover property (commit && is_route);
  c_gain_restart: cover property (commit && is_left && (cnt_r != '0));
  c_level_write: cover property (commit && is_level);
  c_unmapped: cover property (o_pready && o_pslverr);
  c_settled: cover property ($rose(o_left_gain_done));

endmodule // lomr_regs

// ===== verification/tb_top.sv
// Self-checking bench for the line output mixer register slice
`timescale 1ns/1ps
module tb_top
  import lomr_pkg::*;
;
  // ----------------------------------------------------------
  // Stimulus, model and counters
  // ----------------------------------------------------------
  logic              i_sys_clk = 1'b0;
  logic              i_srst    = 1'b1;
  logic              i_psel    = 1'b0;
  logic              i_penable = 1'b0;
  logic              i_pwrite  = 1'b0;
  logic [ADDR_W-1:0] i_paddr   = '0;
  logic [DATA_W-1:0] i_pwdata  = '0;
  logic [3:0]        i_pstrb   = 4'h0;
  logic              o_pready, o_pslverr, o_left_unmute;
  logic              o_left_power, o_left_gain_done;
  logic [DATA_W-1:0] o_prdata;
  logic [7:0]        o_route_en;
  logic [55:0]       o_route_vol;
  logic [3:0]        o_left_level;
  logic [7:0]        mdl [256];
  logic [7:0]        ridx [8] = '{IDX_LA_LL, IDX_LD_LL, IDX_RA_LL,
                                  IDX_RD_LL, IDX_LA_RL, IDX_LD_RL,
                                  IDX_RA_RL, IDX_RD_RL};
  logic [31:0]       rd;
  logic              er;
  logic [7:0]        lv;
  int                n_errors  = 0;
  int                cmp_count = 0;

  always #5 i_sys_clk = ~i_sys_clk;

  lomr_regs lomr_regs_i (.i_sys_clk(i_sys_clk), .i_srst(i_srst),
    .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite),
    .i_paddr(i_paddr), .i_pwdata(i_pwdata), .i_pstrb(i_pstrb),
    .o_pready(o_pready), .o_prdata(o_prdata), .o_pslverr(o_pslverr),
    .o_route_en(o_route_en), .o_route_vol(o_route_vol),
    .o_left_level(o_left_level), .o_left_unmute(o_left_unmute),
    .o_left_power(o_left_power), .o_left_gain_done(o_left_gain_done));

  // ----------------------------------------------------------
  // Checking and bus tasks
  // ----------------------------------------------------------
  task automatic chk(input string nm, input logic [63:0] seen,
                     input logic [63:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic test_done();
    $display("errors %0d comparisons %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // One APB transfer; holds the request until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d, input logic [3:0] st);
    int n;
    n = 0;
    @(posedge i_sys_clk);
    i_psel <= 1'b1;
    i_penable <= 1'b0;
    i_pwrite <= wr;
    i_paddr <= a;
    i_pwdata <= d;
    i_pstrb <= st;
    @(posedge i_sys_clk);
    i_penable <= 1'b1;
    // No cap here: only the watchdog ends a wait that never answers
    do begin
      @(posedge i_sys_clk);
      n++;
    end while (o_pready !== 1'b1);
    chk("pready_wait", n, 2);
    rd = o_prdata;
    er = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
  endtask

  function automatic bit mapped(input logic [7:0] i);
    return i >= IDX_RSVD_A && i <= IDX_RD_RL;
  endfunction

  // Model update follows the access kind of each index
  task automatic wreg(input logic [7:0] i, input logic [7:0] d,
                      input logic [3:0] st);
    apb(1'b1, {2'b00, i, 2'b00}, {24'h00_0000, d}, st);
    chk("wr_err", er, !mapped(i));
    if (st[0] && mapped(i) && i > IDX_RSVD_B)
      mdl[i] = (i == IDX_LEVEL) ? {d[7:3], 3'b010} | d[0] : d;
  endtask

  task automatic rreg(input logic [7:0] i);
    apb(1'b0, {2'b00, i, 2'b00}, 32'h0000_0000, 4'h0);
    chk("rd_data", rd, {24'h00_0000, mdl[i]});
    chk("rd_err", er, !mapped(i));
  endtask

  task automatic outs();
    for (int g = 0; g < 8; g++) begin
      chk("route_en", o_route_en[g], mdl[ridx[g]][7]);
      chk("route_vol", o_route_vol[g*7+:7], mdl[ridx[g]][6:0]);
    end
    chk("level", o_left_level, mdl[IDX_LEVEL][7:4]);
    chk("unmute", o_left_unmute, mdl[IDX_LEVEL][3]);
    chk("power", o_left_power, mdl[IDX_LEVEL][0]);
  endtask

  // ----------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------
  initial begin
    void'($urandom(86576));
    foreach (mdl[k]) mdl[k] = 8'h00;
    mdl[IDX_RSVD_A] = 8'h02;
    mdl[IDX_LEVEL] = 8'h02;
    repeat (12) @(posedge i_sys_clk);
    i_srst <= 1'b0;
    // Reset values of every index plus both neighbours
    for (int i = 'h4e; i <= 'h5d; i++) rreg(i[7:0]);
    outs();
    // Random contents, level codes kept legal, bit 2 written as 0
    for (int k = 0; k < 3; k++) begin
      for (int i = 'h4e; i <= 'h5d; i++) begin
        // Reserved storage is never written by software
        if (i == IDX_RSVD_C || i == IDX_RSVD_D || i == IDX_RSVD_E)
          continue;
        lv = {4'($urandom % 10), 4'($urandom) & 4'hb};
        if (i == IDX_LEVEL)
          wreg(i[7:0], lv, 4'h1);
        else
          wreg(i[7:0], 8'($urandom), 4'($urandom) | 4'h1);
      end
      repeat (SETTLE_CYC + 10) @(posedge i_sys_clk);
      for (int i = 'h4e; i <= 'h5d; i++) rreg(i[7:0]);
      outs();
    end
    // Strobe off and misaligned address leave contents alone
    wreg(IDX_LA_LL, ~mdl[IDX_LA_LL], 4'h0);
    apb(1'b1, {2'b00, IDX_LD_LL, 2'b01}, 32'h0000_00ff, 4'hf);
    chk("misalign_err", er, 1'b1);
    rreg(IDX_LA_LL);
    rreg(IDX_LD_LL);
    // Pending gain shows in the status bit and restarts per write
    wreg(IDX_RA_RL, 8'h11, 4'h1);
    #1 chk("done_right", o_left_gain_done, 1'b1);
    wreg(IDX_LA_LL, 8'h85, 4'h1);
    apb(1'b0, {2'b00, IDX_LEVEL, 2'b00}, 32'h0000_0000, 4'h0);
    chk("done_rd", rd[1], 1'b0);
    repeat (40) @(posedge i_sys_clk);
    wreg(IDX_LEVEL, 8'h99, 4'h1);
    repeat (SETTLE_CYC - 1) @(posedge i_sys_clk);
    #1 chk("done_99", o_left_gain_done, 1'b0);
    @(posedge i_sys_clk);
    #1 chk("done_100", o_left_gain_done, 1'b1);
    rreg(IDX_LEVEL);
    outs();
    test_done();
  end

  // Whole run is under a thousand cycles; this cuts off a hang
  initial begin
    #400000;
    n_errors++;
    test_done();
  end
endmodule // tb_top
